// ---- hdl/flash_write_protection_logic.sv ----
// write-enable latch, otp guard and block range protection of a serial flash
`timescale 1ns/1ps
`include "wp_defs.svh"
module flash_write_protection_logic import wp_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  output logic so,
  output logic so_oe_n,
  input wire logic write_protect_pin_n,
  input wire logic persistent_sector_bit,
  input wire logic dynamic_sector_bit,
  output logic [23:0] array_addr,
  output logic [7:0] array_wdata,
  output logic array_req,
  output array_kind_e array_kind
);
  // ************************************************************
  // functions
  // ************************************************************
  // range fraction decode
  // range protection: n upper address bits all ones (top) or all zeros (bottom)
  function automatic logic bp_hit(input logic [23:0] a, input logic [2:0] bp, input logic tb);
    logic [5:0] top;
    logic [5:0] msk;
    top = tb ? ~a[23:18] : a[23:18];
    msk = 6'(6'h3F << (bp - 3'h1));
    return (bp == 3'h7) || ((bp != 3'h0) && ((top & msk) == msk));
  endfunction

  // a lock bit at 0 means the region is locked
  function automatic logic otp_locked(input logic [9:0] a, input logic [31:0] lk);
    if (a[9:5] == 5'h00) begin
      return a[4] & ~lk[0];
    end
    return ~lk[a[9:5]];
  endfunction

  // ************************************************************
  // link synchronisers
  // ************************************************************
  logic sck_m_r, sck_s_r, sck_d_r;
  logic cs_m_r, cs_s_r, cs_d_r;
  logic si_m_r, si_s_r;
  logic wp_m_r, wp_s_r;

  // all link pins are asynchronous to pclk; first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {sck_m_r, sck_s_r, sck_d_r} <= 3'h0;
      {cs_m_r, cs_s_r, cs_d_r} <= 3'h7;
      {si_m_r, si_s_r} <= 2'h0;
      {wp_m_r, wp_s_r} <= 2'h3;
    end else begin
      {sck_m_r, sck_s_r, sck_d_r} <= {sck, sck_m_r, sck_s_r};
      {cs_m_r, cs_s_r, cs_d_r} <= {cs_n, cs_m_r, cs_s_r};
      {si_m_r, si_s_r} <= {si, si_m_r};
      {wp_m_r, wp_s_r} <= {write_protect_pin_n, wp_m_r};
    end
  end

  // edges of the link clock and the frame
  wire sck_rise = sck_s_r & ~sck_d_r & ~cs_s_r;
  wire sck_fall = ~sck_s_r & sck_d_r & ~cs_s_r;
  wire cs_end = cs_s_r & ~cs_d_r;

  // ************************************************************
  // state
  // ************************************************************
  link_state_e state_r, state_nxt;
  logic [7:0] sh_r, op_r, tx_r, wrr_b0_r, wrr_b1_r;
  logic [2:0] bitc_r;
  logic [1:0] bytc_r, wrr_n_r;
  logic [23:0] addr_r, probe_r;
  logic gate_r, wel_r, perr_r, status_write_lock_r, tb_r, freeze_r, blocked_r, drive_r;
  logic [2:0] bp_r;
  // these are non-volatile and so survive reset, like the store itself
  logic [31:0] lock_r = `LOCK_INIT;
  logic [63:0] once_r = '0;
  logic [63:0] ecc_off_r = '0;
  logic [63:0] touch_r;
  logic so_r, req_r;
  logic oe_n_r;
  logic [7:0] wd_r;
  array_kind_e kind_r;
  logic [31:0] prdata_r;
  logic pready_r, pslverr_r;
  otp_mem_if otp_bus();

  otp_store u_store (
    .pclk(pclk),
    .port(otp_bus.mem)
  );

  // ************************************************************
  // decode
  // ************************************************************
  wire [7:0] sh_nxt = {sh_r[6:0], si_s_r};
  wire byte_done = sck_rise & (bitc_r == 3'h7);
  wire op_pw = (op_r == `CMD_PAGE_WRITE) || (op_r == `CMD_QUAD_PAGE_WRITE);
  wire op_otpw = op_r == `CMD_OTP_WRITE;
  wire op_otpr = op_r == `CMD_OTP_READ;
  wire op_sr = op_r == `CMD_STATUS_READ;
  wire op_wrr = op_r == `CMD_REG_WRITE;
  wire has_addr = (sh_nxt == `CMD_PAGE_WRITE) || (sh_nxt == `CMD_QUAD_PAGE_WRITE) ||
                  (sh_nxt == `CMD_OTP_WRITE) || (sh_nxt == `CMD_OTP_READ) || (sh_nxt == `CMD_BLOCK64_WIPE);
  wire data_byte = byte_done & (state_r == st_data);
  wire otp_in_range = addr_r[23:10] == 14'h0000;
  wire main_prot = bp_hit(addr_r, bp_r, tb_r) | ~persistent_sector_bit | ~dynamic_sector_bit;
  wire chip_prot = bp_r != 3'h0;
  wire [5:0] portion = addr_r[9:4];
  wire [7:0] sr1 = {status_write_lock_r, perr_r, 1'b0, bp_r, wel_r, 1'b0};
  wire [7:0] cr = {2'h0, tb_r, 4'h0, freeze_r};
  wire hw_locked = ~wp_s_r & status_write_lock_r;
  wire pw_ok = gate_r & ~main_prot;
  // out-of-range otp ignored
  // otp byte accepted only if latched, unfrozen, in range and its region unlocked
  wire otp_ok = gate_r & ~freeze_r & otp_in_range & ~otp_locked(addr_r[9:0], lock_r);
  wire otp_we = data_byte & op_otpw & otp_ok;
  wire lock_word = addr_r[9:2] == `LOCK_BYTE_WORD;
  wire apb_wr = psel & penable & pready_r & pwrite;
  wire soft_rst = apb_wr & (paddr == `REG_CTRL) & pwdata[`CTRL_SOFT_RESET];
  wire err_clr = apb_wr & (paddr == `REG_CTRL) & pwdata[`CTRL_ERR_CLEAR];
  wire fin_otp = cs_end & op_otpw & gate_r;
  wire fin_wipe = cs_end & gate_r & ((op_r == `CMD_BLOCK64_WIPE) || (op_r == `CMD_CHIP_WIPE));
  wire wipe_prot = (op_r == `CMD_CHIP_WIPE) ? chip_prot : main_prot;
  wire fin_wrr = cs_end & op_wrr & gate_r & (wrr_n_r != 2'h0);

  // read bytes come from the otp store; past 1 KB the address simply wraps
  assign otp_bus.we = otp_we;
  assign otp_bus.addr = addr_r[9:0];
  assign otp_bus.wdata = sh_nxt;

  // ************************************************************
  // command sequencing
  // ************************************************************
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      st_op: state_nxt = has_addr ? st_addr : ((sh_nxt == `CMD_REG_WRITE) ||
                         (sh_nxt == `CMD_STATUS_READ)) ? st_data : st_skip;
      st_addr: state_nxt = (bytc_r != 2'h2) ? st_addr : op_otpr ? st_dummy :
                           (op_r == `CMD_BLOCK64_WIPE) ? st_skip : st_data;
      st_dummy: state_nxt = st_data;
      st_data: state_nxt = st_data;
      st_skip: state_nxt = st_skip;
      default: state_nxt = st_skip;
    endcase
  end

  // byte assembly and address collection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= st_op;
      {sh_r, op_r, bitc_r, bytc_r, addr_r} <= '0;
    end else if (cs_end) begin
      state_r <= st_op;
      bitc_r <= 3'h0;
      bytc_r <= 2'h0;
    end else if (sck_rise) begin
      sh_r <= sh_nxt;
      bitc_r <= bitc_r + 3'h1;
      if (byte_done) begin
        state_r <= state_nxt;
        bytc_r <= (state_r == st_addr) ? bytc_r + 2'h1 : 2'h0;
        if (state_r == st_op) op_r <= sh_nxt;
        if (state_r == st_addr) addr_r <= {addr_r[15:0], sh_nxt};
        if ((state_r == st_data && !op_sr && !op_wrr) || (state_r == st_dummy)) addr_r <= addr_r + 24'h1;
      end
    end
  end

  // ************************************************************
  // read path: status and otp bytes shifted out on falling sck
  // ************************************************************
  // status and otp read stream
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {tx_r, so_r, drive_r} <= '0;
    end else if (cs_end) begin
      drive_r <= 1'b0;
    end else if (byte_done && (state_r == st_op) && (sh_nxt == `CMD_STATUS_READ)) begin
      tx_r <= sr1;
      drive_r <= 1'b1;
    end else if (byte_done && op_otpr && (state_r == st_dummy || state_r == st_data)) begin
      tx_r <= otp_bus.rdata;
      drive_r <= 1'b1;
    end else if (byte_done && op_sr) begin
      tx_r <= sr1;
    end else if (sck_fall && drive_r) begin
      so_r <= tx_r[7];
      tx_r <= {tx_r[6:0], 1'b1};
    end
  end

  // enable comes from its own flop so the pin is glitch free
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) oe_n_r <= 1'b1;
    else oe_n_r <= ~drive_r;
  end

  // ************************************************************
  // write latch, status and configuration
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {gate_r, wel_r, perr_r, status_write_lock_r, tb_r, freeze_r, blocked_r} <= '0;
      {bp_r, wrr_b0_r, wrr_b1_r, wrr_n_r} <= '0;
    end else begin
      // latch sampled when the opcode is taken
      if (byte_done && state_r == st_op) begin
        gate_r <= wel_r;
        blocked_r <= 1'b0;
        wrr_n_r <= 2'h0;
      end
      if (data_byte && op_wrr && wrr_n_r != 2'h2) begin
        wrr_n_r <= wrr_n_r + 2'h1;
        if (wrr_n_r == 2'h0) wrr_b0_r <= sh_nxt;
        else wrr_b1_r <= sh_nxt;
      end
      if (data_byte && ((op_pw && !pw_ok) || (op_otpw && !otp_ok))) blocked_r <= 1'b1;
      // latch cleared after a completed modifying command or soft reset
      if (soft_rst || (cs_end && op_r == `CMD_LATCH_CLEAR) || (cs_end && gate_r && (op_pw || op_wrr)) ||
          fin_wipe || (fin_otp && !freeze_r && otp_in_range)) wel_r <= 1'b0;
      // latch set wins over any clear in the same cycle
      if (cs_end && op_r == `CMD_LATCH_SET) wel_r <= 1'b1;
      // otp program under config lock fails; error set wins over clear
      if (err_clr) perr_r <= 1'b0;
      if ((fin_otp && freeze_r) || (fin_wipe && wipe_prot) || (cs_end && gate_r && op_pw && blocked_r))
        perr_r <= 1'b1;
      // pin low with status lock rejects every register change
      if (fin_wrr && !hw_locked) begin
        status_write_lock_r <= wrr_b0_r[`SR1_STATUS_WRITE_LOCK];
        // frozen range bits silently kept, no error
        if (!freeze_r) begin
          bp_r <= wrr_b0_r[`SR1_BP_LO +: 3];
          if (wrr_n_r == 2'h2) tb_r <= wrr_b1_r[`CR_TBSEL];
        end
        // config lock only ever sets until reset
        if (wrr_n_r == 2'h2) freeze_r <= freeze_r | wrr_b1_r[`CR_FREEZE];
      end
    end
  end

  // ************************************************************
  // otp lock mirror and ecc bookkeeping
  // ************************************************************
  // second program of a 16-byte portion disables its ecc
  always_ff @(posedge pclk) begin
    if (otp_we) begin
      once_r[portion] <= 1'b1;
      if (once_r[portion] && !touch_r[portion]) ecc_off_r[portion] <= 1'b1;
      // lock bytes are mirrored so checks need no store read
      if (lock_word) lock_r[addr_r[1:0]*8 +: 8] <= lock_r[addr_r[1:0]*8 +: 8] & sh_nxt;
    end
  end

  // bytes of one frame count as one program operation
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) touch_r <= '0;
    else if (byte_done && state_r == st_op) touch_r <= '0;
    else if (otp_we) touch_r[portion] <= 1'b1;
  end

  // ************************************************************
  // array requests
  // ************************************************************
  // page writes and block wipes reach the array only when unprotected; chip wipe is held back by the range bits alone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_r <= 1'b0;
      wd_r <= 8'h00;
      kind_r <= ak_prog;
    end else begin
      req_r <= (data_byte && op_pw && pw_ok) || (fin_wipe && !wipe_prot);
      if (data_byte) wd_r <= sh_nxt;
      if (data_byte) kind_r <= ak_prog;
      else if (fin_wipe) kind_r <= (op_r == `CMD_CHIP_WIPE) ? ak_chip : ak_erase;
    end
  end

  // ************************************************************
  // apb slave: no wait state, registered answer
  // ************************************************************
  wire [31:0] rd_mux = (paddr == `REG_STATUS) ? {16'h0000, cr, sr1} :
                       (paddr == `REG_PROBE) ? {bp_hit(probe_r, bp_r, tb_r), 7'h00, probe_r} :
                       (paddr == `REG_ECC_LO) ? ecc_off_r[31:0] :
                       (paddr == `REG_ECC_HI) ? ecc_off_r[63:32] :
                       (paddr == `REG_LOCK) ? lock_r : 32'h00000000;
  wire mapped = (paddr == `REG_STATUS) || (paddr == `REG_CTRL) || (paddr == `REG_PROBE) ||
                (paddr == `REG_ECC_LO) || (paddr == `REG_ECC_HI) || (paddr == `REG_LOCK);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {pready_r, pslverr_r, prdata_r, probe_r} <= '0;
    end else begin
      pready_r <= psel & ~penable & ~pready_r;
      pslverr_r <= psel & ~penable & ~mapped;
      prdata_r <= (psel & ~penable & ~pwrite) ? rd_mux : 32'h00000000;
      if (apb_wr && paddr == `REG_PROBE) probe_r <= pwdata[23:0];
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign so = so_r;
  assign so_oe_n = oe_n_r;
  assign array_addr = addr_r;
  assign array_wdata = wd_r;
  assign array_req = req_r;
  assign array_kind = kind_r;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  latch_set_a: assert property (cs_end && op_r == `CMD_LATCH_SET |=> wel_r)
    else $error("write latch not set");
  latch_clear_a: assert property (cs_end && gate_r && (op_pw || op_wrr) && op_r != `CMD_LATCH_SET |=> !wel_r)
    else $error("write latch not cleared");
  range_keep_a: assert property (fin_otp && !freeze_r && !otp_in_range && wel_r |=> wel_r)
    else $error("latch lost on out of range otp program");
  frozen_err_a: assert property (fin_otp && freeze_r |=> perr_r)
    else $error("no program error under config lock");
  freeze_hold_a: assert property (freeze_r |=> freeze_r && $stable(bp_r) && $stable(tb_r))
    else $error("frozen bits changed");
  pin_lock_a: assert property (hw_locked |=> $stable(status_write_lock_r) && $stable(bp_r) && $stable(freeze_r))
    else $error("register changed under pin lock");
  otp_guard_a: assert property (otp_bus.we |-> !freeze_r && otp_in_range && !otp_locked(addr_r[9:0], lock_r))
    else $error("locked otp byte written");
  array_gate_a: assert property (req_r && kind_r == ak_prog |-> $past(gate_r) && !$past(main_prot))
    else $error("array program without latch or into protected sector");
  ecc_first_a: assert property (otp_bus.we && !once_r[portion] |=> !ecc_off_r[$past(portion)])
    else $error("ecc dropped on first program");
endmodule

// ---- hdl/otp_mem_if.sv ----
// signals between the protection logic and the otp store
`timescale 1ns/1ps
interface otp_mem_if;
  logic we;
  logic [9:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport ctl (output we, output addr, output wdata, input rdata);
  modport mem (input we, input addr, input wdata, output rdata);
endinterface

// ---- hdl/otp_store.sv ----
// 1024-byte one-time-programmable store with registered read
`timescale 1ns/1ps
module otp_store (
  input wire logic pclk,
  otp_mem_if.mem port
);
  // separate erased store
  // erased cells start at all ones; there is no erase path at all
  logic [7:0] mem_r [0:1023] = '{default: 8'hFF};
  logic [7:0] rdata_r;

  // programming can only clear bits, so repeated writes accumulate
  always_ff @(posedge pclk) begin
    if (port.we) begin
      mem_r[port.addr] <= mem_r[port.addr] & port.wdata;
    end
    rdata_r <= mem_r[port.addr];
  end

  assign port.rdata = rdata_r;
endmodule

// ---- hdl/wp_defs.svh ----
// constants of the flash write-protection block: offsets, fields, opcodes
`ifndef WP_DEFS_SVH
`define WP_DEFS_SVH

// ************************************************************
// register offsets (apb byte addresses)
// ************************************************************
`define REG_STATUS 12'h000
`define REG_CTRL 12'h004
`define REG_PROBE 12'h008
`define REG_ECC_LO 12'h00C
`define REG_ECC_HI 12'h010
`define REG_LOCK 12'h014

// ************************************************************
// fields
// ************************************************************
`define CTRL_SOFT_RESET 0
`define CTRL_ERR_CLEAR 1
`define PROBE_HIT 31
`define SR1_WEL 1
`define SR1_BP_LO 2
`define SR1_PERR 6
`define SR1_STATUS_WRITE_LOCK 7
`define CR_FREEZE 0
`define CR_TBSEL 5
`define LOCK_BYTE_WORD 8'h04
`define OTP_AW 10
`define ARRAY_AW 24

// ************************************************************
// reset values and link opcodes
// ************************************************************
`define LOCK_INIT 32'hFFFFFFFF
`define CMD_LATCH_SET 8'h06
`define CMD_LATCH_CLEAR 8'h04
`define CMD_REG_WRITE 8'h01
`define CMD_STATUS_READ 8'h05
`define CMD_PAGE_WRITE 8'h02
`define CMD_QUAD_PAGE_WRITE 8'h32
`define CMD_BLOCK64_WIPE 8'hD8
`define CMD_CHIP_WIPE 8'hC7
`define CMD_OTP_WRITE 8'h42
`define CMD_OTP_READ 8'h4B

`endif

// ---- hdl/wp_pkg.sv ----
// types shared by the write-protection block
package wp_pkg;
  typedef enum logic [2:0] {st_op, st_addr, st_dummy, st_data, st_skip} link_state_e;
  typedef enum logic [1:0] {ak_prog, ak_erase, ak_chip} array_kind_e;
endpackage

// ---- test/flash_write_protection_logic_tb.sv ----
// self-checking bench for the flash write-protection block
`timescale 1ns/1ps
`include "wp_defs.svh"
module flash_write_protection_logic_tb import wp_pkg::*; ;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic sck, cs_n, si, so, so_oe_n, array_req;
  logic write_protect_pin_n, persistent_sector_bit, dynamic_sector_bit;
  logic [23:0] array_addr;
  logic [7:0] array_wdata, seen_data;
  array_kind_e array_kind, seen_kind;
  int n_errors, n_tests, n_req, nr;
  typedef struct {logic tb; logic [2:0] bp; logic [23:0] a; logic hit;} row_s;
  // range edges: bottom select, range bits, probe address, expected hit
  row_s rows [10] = '{'{0, 0, 24'hFFFFFF, 0}, '{0, 1, 24'hFC0000, 1}, '{0, 1, 24'hFBFFFF, 0},
    '{0, 6, 24'h800000, 1}, '{0, 7, 24'h000000, 1}, '{1, 1, 24'h03FFFF, 1}, '{1, 1, 24'h040000, 0},
    '{1, 5, 24'h3FFFFF, 1}, '{1, 6, 24'h800000, 0}, '{1, 0, 24'h000000, 0}};
  flash_write_protection_logic dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .sck, .cs_n, .si, .so, .so_oe_n, .write_protect_pin_n, .persistent_sector_bit,
    .dynamic_sector_bit, .array_addr, .array_wdata, .array_req, .array_kind);
  spi_host host (.pclk, .so, .sck, .cs_n, .si);
  // ************************************************************
  // clock, array monitor, checking tasks
  // ************************************************************
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // counts array requests and keeps what the last one carried
  always @(posedge pclk) begin
    if (array_req === 1'b1) begin
      n_req <= n_req + 1;
      seen_kind <= array_kind;
      seen_data <= array_wdata;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("tests=%0d errors=%0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // one apb transfer; the extra edge keeps psel from being set twice in one step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d); apb(1'b1, a, d); endtask
  task automatic rd(input logic [11:0] a); apb(1'b0, a, 32'h0); endtask
  task automatic st(input logic [31:0] exp);
    rd(`REG_STATUS);
    chk(rdat, exp);
  endtask
  task automatic spi(input logic [47:0] b, input int n);
    for (int i = 0; i < 6; i++) begin
      host.tx[i] = b[47 - 8 * i -: 8];
    end
    host.frame(n);
  endtask
  task automatic write_latch_set_cmd(); spi({`CMD_LATCH_SET, 40'h0}, 1); endtask
  task automatic regw(input logic [7:0] sr, input logic [7:0] cr);
    write_latch_set_cmd();
    spi({`CMD_REG_WRITE, sr, cr, 24'h0}, 3);
  endtask
  task automatic otpw(input logic [23:0] a, input logic [7:0] d);
    write_latch_set_cmd();
    spi({`CMD_OTP_WRITE, a, d, 8'h0}, 5);
  endtask
  task automatic otpr(input logic [23:0] a); spi({`CMD_OTP_READ, a, 16'h0}, 6); endtask
  task automatic do_reset();
    presetn <= 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
  endtask
  // ************************************************************
  // watchdog and main sequence
  // ************************************************************
  initial begin
    #1500000;
    n_errors++;
    test_done();
  end
  initial begin
    {presetn, psel, penable, pwrite} = 4'h0;
    {paddr, pwdata} = 44'h0;
    {write_protect_pin_n, persistent_sector_bit, dynamic_sector_bit} = 3'h7;
    {n_errors, n_tests, n_req} = '0;
    @(posedge pclk);
    do_reset();
    st(32'h0); // reset clears latch
    rd(`REG_LOCK);
    chk(rdat, `LOCK_INIT); // all regions open
    rd(12'h020);
    chk({err, rdat[30:0]}, 32'h80000000);
    foreach (rows[i]) begin
      regw({3'h0, rows[i].bp, 2'h0}, {2'h0, rows[i].tb, 5'h0});
      wr(`REG_PROBE, {8'h0, rows[i].a});
      rd(`REG_PROBE);
      chk({rdat[31], rdat[23:0]}, {rows[i].hit, rows[i].a}); // range decode
      st({18'h0, rows[i].tb, 8'h0, rows[i].bp, 2'h0}); // reg write clears latch
    end
    regw(8'h00, 8'h00);
    write_latch_set_cmd();
    st(32'h2); // latch set
    spi({`CMD_STATUS_READ, 40'h0}, 2);
    chk(host.rx, 8'h02); // latch seen on link
    chk(so_oe_n, 1'b1); // output released after frame
    spi({`CMD_LATCH_CLEAR, 40'h0}, 1);
    st(32'h0); // latch clear command
    write_latch_set_cmd();
    wr(`REG_CTRL, 32'h1);
    st(32'h0); // soft reset
    nr = n_req;
    spi({`CMD_PAGE_WRITE, 24'h000100, 8'h3C, 8'h0}, 5);
    chk(n_req - nr, 0); // no latch no write
    write_latch_set_cmd();
    spi({`CMD_PAGE_WRITE, 24'h000100, 8'h3C, 8'h0}, 5);
    chk(n_req - nr, 1); // latched write runs
    chk({seen_kind, seen_data}, {ak_prog, 8'h3C});
    chk(array_addr, 24'h000101); // address stepped past byte
    st(32'h0); // page write clears latch
    // each sector bit alone guards a page write; range bits are zero here
    for (int k = 0; k < 2; k++) begin
      {persistent_sector_bit, dynamic_sector_bit} <= k ? 2'h2 : 2'h1;
      nr = n_req;
      write_latch_set_cmd();
      spi({`CMD_PAGE_WRITE, 24'h000100, 8'h3C, 8'h0}, 5);
      chk(n_req - nr, 0); // sector bit guards
      rd(`REG_STATUS);
      chk(rdat | 32'h2, 32'h42);
      wr(`REG_CTRL, 32'h2);
    end
    {persistent_sector_bit, dynamic_sector_bit} <= 2'h3;
    regw(8'h04, 8'h00);
    nr = n_req;
    write_latch_set_cmd();
    spi({`CMD_CHIP_WIPE, 40'h0}, 1);
    chk(n_req - nr, 0); // chip wipe refused
    write_latch_set_cmd();
    spi({`CMD_BLOCK64_WIPE, 24'h000000, 16'h0}, 4);
    chk({seen_kind, 8'h0} | (n_req - nr), {ak_erase, 8'h1}); // lower part open
    regw(8'h00, 8'h00);
    write_latch_set_cmd();
    spi({`CMD_CHIP_WIPE, 40'h0}, 1);
    chk(seen_kind, ak_chip); // no range no guard
    wr(`REG_CTRL, 32'h2);
    otpw(24'h000020, 8'hA5);
    rd(`REG_ECC_LO);
    chk(rdat, 32'h0); // ecc kept
    otpw(24'h000020, 8'h0F);
    rd(`REG_ECC_LO);
    chk(rdat, 32'h4); // reprogram drops ecc
    otpr(24'h000020);
    chk(host.rx, 8'h05); // repeat program
    otpw(24'h000010, 8'hFC);
    rd(`REG_LOCK);
    chk(rdat, 32'hFFFFFFFC); // lock mirror
    otpw(24'h000018, 8'h00);
    otpw(24'h000030, 8'h00);
    otpw(24'h000000, 8'h5A);
    otpr(24'h000018);
    chk(host.rx, 8'hFF); // upper half locked
    otpr(24'h000030);
    chk(host.rx, 8'hFF); // region 1 locked
    otpr(24'h000000);
    chk(host.rx, 8'h5A); // lower half open
    wr(`REG_CTRL, 32'h2);
    otpw(24'h000400, 8'h00);
    st(32'h2); // out of range keeps latch
    regw(8'h80, 8'h00);
    write_protect_pin_n <= 1'b0;
    regw(8'h04, 8'h20);
    rd(`REG_STATUS);
    chk(rdat | 32'h2, 32'h82); // pin lock
    write_protect_pin_n <= 1'b1;
    regw(8'h00, 8'h00);
    st(32'h0); // pin released
    regw(8'h04, 8'h01);
    regw(8'h00, 8'h20);
    st(32'h0104); // frozen, no error
    otpw(24'h000040, 8'h00);
    st(32'h0146); // frozen otp write fails
    otpr(24'h000040);
    chk(host.rx, 8'hFF); // store unchanged
    do_reset();
    st(32'h0); // reset clears
    otpr(24'h000020);
    chk(host.rx, 8'h05); // otp survives reset
    test_done();
  end
endmodule

// ---- test/spi_host.sv ----
// spi host model sending mode-0 command frames to the flash block
`timescale 1ns/1ps
module spi_host (
  input wire logic pclk,
  input wire logic so,
  output logic sck,
  output logic cs_n,
  output logic si
);
  logic [7:0] tx [0:5];
  logic [7:0] rx;
  // idle: sck stands low, cs_n high
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
    rx = 8'h00;
  end
  // n bytes msb first; 8 pclk per sck period, 4 pclk low and 4 pclk high
  task automatic frame(input int n);
    cs_n <= 1'b0;
    repeat (4) @(posedge pclk);
    for (int i = 0; i < n * 8; i++) begin
      sck <= 1'b0;
      si <= tx[i / 8][7 - i % 8];
      repeat (4) @(posedge pclk);
      sck <= 1'b1;
      repeat (4) @(posedge pclk);
      rx = {rx[6:0], so};
    end
    sck <= 1'b0;
    repeat (4) @(posedge pclk);
    cs_n <= 1'b1;
    // released si flips so no stale bit looks valid
    si <= ~si;
    repeat (8) @(posedge pclk);
  endtask
endmodule
